// >>> rtl/driver_ctrl_defines.svh
// Constants for the octal driver serial control and fault logic
`ifndef DRIVER_CTRL_DEFINES_SVH
`define DRIVER_CTRL_DEFINES_SVH
`define FRAME_BITS 16
`define FILTER_TIME_US 100
`define CLOCK_MHZ 100
`define FILTER_CYCLES (`FILTER_TIME_US * `CLOCK_MHZ)
`define REG_RESET 16'h0000
`define RESP_WARN_BIT 0
`define RESP_STATUS_LSB 1
`define RESP_INPUT_LSB 9
`define RESP_SUPPLY_BIT 15
`define CMD_OPEN_LSB 8
`endif

// >>> rtl/driver_ctrl_pkg.sv
// Types for the octal driver serial control and fault logic
package driver_ctrl_pkg;
   typedef enum logic [1:0] {
      LINK_IDLE = 2'b00,
      LINK_SHIFT = 2'b01
   } link_state_t;
   typedef logic [7:0] chan_vec_t;
endpackage

// >>> rtl/fault_filter.sv
// Persistence filter timer: output rises after the event holds a full window
`timescale 1ns/100ps
`default_nettype none
module fault_filter #(
   parameter int CYCLES = 10000
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic event_in,
   output logic seen
);
   localparam int CW = $clog2(CYCLES + 1);
   localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);
   logic [CW-1:0] cnt_q, cnt_d;
   logic seen_q, seen_d;
   always_comb begin
      cnt_d = '0;
      seen_d = 1'b0;
      // Any drop restarts the window, so short pulses never report
      if (event_in) begin
         if (cnt_q == LAST) begin
            cnt_d = cnt_q;
            seen_d = 1'b1;
         end else begin
            cnt_d = cnt_q + CW'(1);
         end
      end
   end
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= '0;
         seen_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         seen_q <= seen_d;
      end
   end
   assign seen = seen_q;
endmodule // fault_filter
`default_nettype wire

// >>> rtl/octal_driver_spi_fault_logic.sv
// Serial port, drive combining and fault latches of the eight-channel driver
`timescale 1ns/100ps
`default_nettype none
`include "driver_ctrl_defines.svh"
module octal_driver_spi_fault_logic
   import driver_ctrl_pkg::*;
#(
   parameter int FILTER_CYCLES = `FILTER_CYCLES
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic enable_pin,
   input wire logic chip_select_low_n,
   input wire logic serial_clock,
   input wire logic serial_in,
   output logic serial_out,
   output logic serial_out_en,
   input wire logic [3:0] parallel_drive_inputs_upper,
   input wire logic [7:0] over_current_sense,
   input wire logic [7:0] open_load_sense,
   input wire logic [3:0] pair_warning_sense,
   input wire logic [3:0] pair_shutdown_sense,
   input wire logic supply_fault_sense,
   output logic [7:0] driver_on,
   output logic [7:0] open_load_source_on,
   output logic thermal_warning_flag
);
   logic sync_en, sync_sel, sync_cs_n, sync_sck, sync_si;
   logic [3:0] sync_par;
   // Select synchronised as active high so its reset level matches an idle bus
   pin_sync #(.WIDTH(8)) u_sync (
      .clock(clock),
      .rst_n(rst_n),
      .pin({enable_pin, !chip_select_low_n, serial_clock, serial_in, parallel_drive_inputs_upper}),
      .level({sync_en, sync_sel, sync_sck, sync_si, sync_par})
   );
   assign sync_cs_n = !sync_sel;

   // Enable pin low acts as logic reset, caught synchronously
   logic en_q;
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         en_q <= 1'b0;
      end else begin
         en_q <= sync_en;
      end
   end
   logic soft_clr;
   assign soft_clr = !en_q;

   // Edge detection on synchronised link levels
   logic cs_prev_q, sck_prev_q;
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cs_prev_q <= 1'b1;
         sck_prev_q <= 1'b0;
      end else begin
         cs_prev_q <= sync_cs_n;
         sck_prev_q <= sync_sck;
      end
   end
   logic cs_fall, cs_rise, sck_rise, sck_fall;
   assign cs_fall = cs_prev_q && !sync_cs_n;
   assign cs_rise = !cs_prev_q && sync_cs_n;
   assign sck_rise = !sck_prev_q && sync_sck;
   assign sck_fall = sck_prev_q && !sync_sck;

   // Filtered fault events
   logic [7:0] oc_seen, ol_seen;
   logic [7:0] drv_int, drv_q;
   logic [3:0] warn_seen, shut_seen;
   logic supply_seen;
   logic [15:0] cmd_q, cmd_d;
   genvar g;
   generate
      for (g = 0; g < 8; g++) begin : g_drv
         // One shared timer per driver; a mode change restarts the window
         fault_filter #(.CYCLES(FILTER_CYCLES)) u_filt (
            .clock(clock),
            .rst_n(rst_n),
            .event_in((drv_int[g] == drv_q[g]) && (drv_int[g] ? over_current_sense[g]
                      : (open_load_sense[g] && cmd_q[`CMD_OPEN_LSB + g]))),
            .seen(ol_seen[g])
         );
         // Seen lags one cycle, so the mode that fed it is drv_q
         assign oc_seen[g] = ol_seen[g] && drv_q[g];
      end
      for (g = 0; g < 4; g++) begin : g_pair
         fault_filter #(.CYCLES(1)) u_warn (
            .clock(clock),
            .rst_n(rst_n),
            .event_in(pair_warning_sense[g]),
            .seen(warn_seen[g])
         );
         fault_filter #(.CYCLES(1)) u_shut (
            .clock(clock),
            .rst_n(rst_n),
            .event_in(pair_shutdown_sense[g]),
            .seen(shut_seen[g])
         );
      end
   endgenerate
   fault_filter #(.CYCLES(1)) u_supply (
      .clock(clock),
      .rst_n(rst_n),
      .event_in(supply_fault_sense),
      .seen(supply_seen)
   );

   // Serial shift engine
   link_state_t st_q, st_d;
   logic [15:0] sh_q, sh_d, tx_q, tx_d;
   logic [4:0] cnt_q, cnt_d;
   logic so_q, so_d;
   logic [15:0] resp;
   logic valid_frame;
   always_comb begin
      st_d = st_q;
      sh_d = sh_q;
      tx_d = tx_q;
      cnt_d = cnt_q;
      so_d = so_q;
      valid_frame = 1'b0;
      unique case (st_q)
         LINK_IDLE: begin
            if (cs_fall) begin
               st_d = LINK_SHIFT;
               cnt_d = '0;
               tx_d = resp;
               so_d = resp[`RESP_WARN_BIT];
            end
         end
         LINK_SHIFT: begin
            if (cs_rise) begin
               st_d = LINK_IDLE;
               // Only a whole number of words counts
               valid_frame = (cnt_q[3:0] == 4'h0) && cnt_q[4];
            end else begin
               if (sck_rise) begin
                  sh_d = {sync_si, sh_q[15:1]};
                  cnt_d = {1'b1, cnt_q[3:0] + 4'h1};
                  if (cnt_q[4] == 1'b0 && cnt_q[3:0] != 4'hF) begin
                     cnt_d = {1'b0, cnt_q[3:0] + 4'h1};
                  end
               end
               if (sck_fall) begin
                  // Daisy chain: newest received bit leaves 16 falls later
                  tx_d = {sh_q[15], tx_q[15:1]};
                  so_d = tx_q[1];
               end
            end
         end
         default: st_d = LINK_IDLE;
      endcase
   end
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= LINK_IDLE;
         sh_q <= `REG_RESET;
         tx_q <= `REG_RESET;
         cnt_q <= '0;
         so_q <= 1'b0;
      end else if (soft_clr) begin
         st_q <= LINK_IDLE;
         sh_q <= `REG_RESET;
         tx_q <= `REG_RESET;
         cnt_q <= '0;
         so_q <= 1'b0;
      end else begin
         st_q <= st_d;
         sh_q <= sh_d;
         tx_q <= tx_d;
         cnt_q <= cnt_d;
         so_q <= so_d;
      end
   end

   // Command register and fault latches
   logic [7:0] oc_lat_q, oc_lat_d, ts_lat_q, ts_lat_d;
   logic ps_lat_q, ps_lat_d;
   logic [3:0] par_cap_q, par_cap_d;
   logic frozen_q, frozen_d;
   logic [7:0] shut_mask;
   logic [7:0] cmd_on;
   always_comb begin
      shut_mask = '0;
      for (int p = 0; p < 4; p++) begin
         shut_mask[2*p] = shut_seen[p];
         shut_mask[2*p+1] = shut_seen[p];
      end
   end
   always_comb begin
      cmd_d = cmd_q;
      oc_lat_d = oc_lat_q;
      ts_lat_d = ts_lat_q;
      ps_lat_d = ps_lat_q;
      par_cap_d = par_cap_q;
      frozen_d = frozen_q;
      if (valid_frame) begin
         cmd_d = sh_q;
         oc_lat_d = oc_lat_q & sh_q[7:0];
         for (int p = 0; p < 4; p++) begin
            if (!shut_seen[p] && sh_q[2*p +: 2] == 2'b00) begin
               ts_lat_d[2*p +: 2] = 2'b00;
            end
         end
         if (!supply_seen) begin
            ps_lat_d = 1'b0;
         end
         if ((oc_lat_d | ts_lat_d) == 8'h00) begin
            frozen_d = 1'b0;
         end
      end
      // Set wins over clear
      oc_lat_d = oc_lat_d | oc_seen;
      ts_lat_d = ts_lat_d | shut_mask;
      ps_lat_d = ps_lat_d | supply_seen;
      if ((oc_seen != 8'h00 || shut_mask != 8'h00) && !frozen_d) begin
         frozen_d = 1'b1;
         par_cap_d = sync_par;
      end
   end
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cmd_q <= `REG_RESET;
         oc_lat_q <= '0;
         ts_lat_q <= '0;
         ps_lat_q <= 1'b0;
         par_cap_q <= '0;
         frozen_q <= 1'b0;
      end else if (soft_clr) begin
         cmd_q <= `REG_RESET;
         oc_lat_q <= '0;
         ts_lat_q <= '0;
         ps_lat_q <= 1'b0;
         par_cap_q <= '0;
         frozen_q <= 1'b0;
      end else begin
         cmd_q <= cmd_d;
         oc_lat_q <= oc_lat_d;
         ts_lat_q <= ts_lat_d;
         ps_lat_q <= ps_lat_d;
         par_cap_q <= par_cap_d;
         frozen_q <= frozen_d;
      end
   end

   assign cmd_on = cmd_q[7:0] | {sync_par, 4'h0};
   // Supply fail holds drivers off only while present
   assign drv_int = cmd_on & ~oc_lat_q & ~ts_lat_q & {8{!supply_seen && en_q}};

   // Response word
   logic [7:0] status;
   logic [7:0] ol_report;
   assign ol_report = ol_seen & ~drv_q & cmd_q[15:8];
   assign status = oc_lat_q | ts_lat_q | ol_report;
   always_comb begin
      resp = `REG_RESET;
      resp[`RESP_WARN_BIT] = |warn_seen;
      resp[`RESP_STATUS_LSB +: 8] = status;
      resp[`RESP_INPUT_LSB +: 4] = frozen_q ? par_cap_q : sync_par;
      resp[`RESP_SUPPLY_BIT] = ps_lat_q;
   end

   logic [7:0] ols_q;
   logic warn_q;
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         drv_q <= '0;
         ols_q <= '0;
         warn_q <= 1'b0;
      end else begin
         drv_q <= drv_int;
         ols_q <= cmd_q[15:8] & ~drv_int & {8{en_q && !supply_seen}};
         warn_q <= |warn_seen;
      end
   end
   assign driver_on = drv_q;
   assign open_load_source_on = ols_q;
   assign thermal_warning_flag = warn_q;
   assign serial_out = so_q;
   assign serial_out_en = (st_q == LINK_SHIFT);
endmodule // octal_driver_spi_fault_logic
`default_nettype wire

// >>> rtl/pin_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] pin,
   output logic [WIDTH-1:0] level
);
   logic [WIDTH-1:0] s1_q, s2_q, s3_q, lvl_q, lvl_d;
   always_comb begin
      lvl_d = lvl_q;
      for (int i = 0; i < WIDTH; i++) begin
         if (s2_q[i] == s3_q[i]) begin
            lvl_d[i] = s3_q[i];
         end
      end
   end
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
         lvl_q <= '0;
      end else begin
         s1_q <= pin;
         s2_q <= s1_q;
         s3_q <= s2_q;
         lvl_q <= lvl_d;
      end
   end
   assign level = lvl_q;
endmodule // pin_sync
`default_nettype wire

// >>> testbench/octal_driver_sva.sv
// Port assertions for the octal driver
`timescale 1ns/100ps
`default_nettype none
module octal_driver_sva #(
   parameter int FILTER_CYCLES = 20
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic enable_pin,
   input wire logic chip_select_low_n,
   input wire logic serial_out,
   input wire logic serial_out_en,
   input wire logic [7:0] over_current_sense,
   input wire logic [3:0] pair_warning_sense,
   input wire logic [3:0] pair_shutdown_sense,
   input wire logic supply_fault_sense,
   input wire logic [7:0] driver_on,
   input wire logic [7:0] open_load_source_on,
   input wire logic thermal_warning_flag
);
   int run_q;
   int run_d;
   always_comb begin
      run_d = (driver_on[0] && over_current_sense[0]) ? run_q + 1 : 0;
   end
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) run_q <= 0;
      else run_q <= run_d;
   end
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   chk_oc_filter_bound: assert property (run_q <= FILTER_CYCLES + 6)
      else $error("over current left driver on too long");
   chk_open_source_off: assert property ((open_load_source_on & driver_on) == 8'h00)
      else $error("diag source on with driver on");
   // Enable passes the pin synchroniser, so allow its latency
   chk_enable_clears: assert property (!enable_pin [*8] |-> driver_on == 8'h00)
      else $error("driver on with enable low");
   chk_select_end: assert property ($rose(chip_select_low_n) |-> ##[1:8] !serial_out_en)
      else $error("output enable stuck after select");
   chk_warn_shown: assert property ($fell(chip_select_low_n)
      |-> ##[2:8] (serial_out_en && serial_out == thermal_warning_flag))
      else $error("warning not shown at select");
   chk_warn_set: assert property ((pair_warning_sense != 4'h0) [*4] |-> thermal_warning_flag)
      else $error("warning flag missing");
   chk_warn_free: assert property ((pair_warning_sense == 4'h0) [*4] |-> !thermal_warning_flag)
      else $error("warning flag held");
   chk_pair_off: assert property (pair_shutdown_sense[0] [*4] |-> driver_on[1:0] == 2'b00)
      else $error("hot pair still driven");
   chk_supply_off: assert property (supply_fault_sense [*4] |-> driver_on == 8'h00)
      else $error("driver on during supply fault");
endmodule // octal_driver_sva
`default_nettype wire

// >>> testbench/spi_host_model.sv
// Host serial master that sends frames and collects the response
`timescale 1ns/100ps
`default_nettype none
module spi_host_model (
   output logic cs_n,
   output logic sclk,
   output logic sdi,
   input wire logic sdo
);
   initial begin
      cs_n = 1'b1;
      sclk = 1'b0;
      sdi = 1'b0;
   end
   // Long select margins cover the device's pin synchroniser
   task automatic xfer(input logic [31:0] d, input int n, output logic [31:0] r);
      r = 32'h0000_0000;
      cs_n = 1'b0;
      #300;
      for (int i = 0; i < n; i++) begin
         sdi = d[i];
         #62.5;
         sclk = 1'b1;
         #62.5;
         r[i] = sdo;
         sclk = 1'b0;
      end
      #62.5;
      cs_n = 1'b1;
      sdi = ~sdi;
      #300;
   endtask
endmodule // spi_host_model
`default_nettype wire

// >>> testbench/tb_top.sv
// Self-checking bench for the octal driver serial and fault logic
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   localparam int FC = 20;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic en = 1'b1;
   logic sfs = 1'b0;
   logic cs_n, sclk, sdi, so, so_en, twf;
   logic [3:0] pdi = 4'h0, pws = 4'h0, pss = 4'h0;
   logic [7:0] ocs = 8'h00, ols = 8'h00, drv, ols_on;
   logic [31:0] resp;
   int bad_count = 0, n_checks = 0;
   always #5 clock = ~clock;
   octal_driver_spi_fault_logic #(.FILTER_CYCLES(FC)) u_octal_driver_spi_fault_logic (
      .clock(clock), .rst_n(rst_n), .enable_pin(en), .chip_select_low_n(cs_n),
      .serial_clock(sclk), .serial_in(sdi), .serial_out(so), .serial_out_en(so_en),
      .parallel_drive_inputs_upper(pdi), .over_current_sense(ocs), .open_load_sense(ols),
      .pair_warning_sense(pws), .pair_shutdown_sense(pss), .supply_fault_sense(sfs),
      .driver_on(drv), .open_load_source_on(ols_on), .thermal_warning_flag(twf));
   spi_host_model u_spi_host_model (.cs_n(cs_n), .sclk(sclk), .sdi(sdi), .sdo(so));
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task automatic fr(input logic [31:0] d, input int n);
      u_spi_host_model.xfer(d, n, resp);
      wt(4);
   endtask
   initial begin
      wt(8);
      rst_n = 1'b1;
      wt(10);
      fr(32'h0F0A, 16);
      check(resp[15:0], 16'h0000);
      check(16'(drv), 16'h000A);
      check(16'(ols_on), 16'h0005);
      ols = 8'hFF;
      wt(FC + 10);
      fr(32'h0F0A, 16);
      check(resp[15:0], 16'h000A);
      ols = 8'h00;
      fr(32'h00FF, 15);
      check(16'(drv), 16'h000A);
      fr(32'h00F0_1234, 32);
      check(16'(drv), 16'h00F0);
      check(resp[31:16], 16'h1234);
      fr(32'h0, 16);
      pdi = 4'h5;
      wt(10);
      check(16'(drv), 16'h0050);
      fr(32'h0001, 16);
      check(resp[15:0], 16'h0A00);
      $display("test frame and parallel done");
      pdi = 4'h0;
      ocs = 8'h01;
      wt(FC + 20);
      check(16'(drv), 16'h0000);
      ocs = 8'h00;
      pdi = 4'hF;
      fr(32'h0001, 16);
      check(resp[15:0], 16'h0002);
      check(16'(drv), 16'h00F0);
      pdi = 4'h0;
      fr(32'h0, 16);
      fr(32'h0001, 16);
      check(16'(drv), 16'h0001);
      repeat (5) begin
         ocs = 8'h01;
         wt(FC - 5);
         ocs = 8'h00;
         wt(5);
      end
      fr(32'h0001, 16);
      check(resp[15:0], 16'h0000);
      check(16'(drv), 16'h0001);
      $display("test over current done");
      pss = 4'h1;
      wt(10);
      check(16'(drv), 16'h0000);
      fr(32'h0, 16);
      pss = 4'h0;
      wt(5);
      fr(32'h0003, 16);
      check(16'(drv), 16'h0000);
      fr(32'h0, 16);
      fr(32'h0003, 16);
      check(16'(drv), 16'h0003);
      pws = 4'h2;
      wt(5);
      check(16'(twf), 16'h0001);
      fr(32'h0003, 16);
      check(resp[15:0], 16'h0001);
      pws = 4'h0;
      wt(5);
      check(16'(twf), 16'h0000);
      fr(32'h0003, 16);
      check(resp[15:0], 16'h0000);
      $display("test thermal done");
      sfs = 1'b1;
      wt(10);
      check(16'(drv), 16'h0000);
      sfs = 1'b0;
      wt(10);
      check(16'(drv), 16'h0003);
      fr(32'h0003, 16);
      check(resp[15:0], 16'h8000);
      fr(32'h0003, 16);
      check(resp[15:0], 16'h0000);
      // Long enough to pass the enable synchroniser
      en = 1'b0;
      wt(12);
      en = 1'b1;
      wt(10);
      check(16'(drv), 16'h0000);
      $display("test supply and enable done");
      test_done();
   end
   initial begin
      #500000;
      bad_count++;
      test_done();
   end
endmodule // tb_top
bind octal_driver_spi_fault_logic octal_driver_sva #(.FILTER_CYCLES(FILTER_CYCLES)) u_octal_driver_sva (
   .clock(clock), .rst_n(rst_n), .enable_pin(enable_pin), .chip_select_low_n(chip_select_low_n),
   .serial_out(serial_out), .serial_out_en(serial_out_en), .over_current_sense(over_current_sense),
   .pair_warning_sense(pair_warning_sense), .pair_shutdown_sense(pair_shutdown_sense),
   .supply_fault_sense(supply_fault_sense), .driver_on(driver_on),
   .open_load_source_on(open_load_source_on), .thermal_warning_flag(thermal_warning_flag));
`default_nettype wire
